/* File: pkg/stfs_map.svh */
// stfs_map.svh - offsets, field positions, widths and reset values of the
// storage transfer block. Definitions only; included by bare name.
`ifndef STFS_MAP_SVH
`define STFS_MAP_SVH

// word and address geometry
`define STFS_WORD_W       24
`define STFS_ADDR_W       12
`define STFS_DEPTH        4096
`define STFS_BYTE_W       8
`define STFS_LOW15_W      15
`define STFS_FIELD_W      3

// bus register byte addresses
`define STFS_BUS_AW       5
`define STFS_OFS_CTRL     5'h00
`define STFS_OFS_NEXTLOC  5'h04
`define STFS_OFS_OPERAND  5'h08
`define STFS_OFS_BUFFER   5'h0C
`define STFS_OFS_ORDER    5'h10
`define STFS_OFS_STATUS   5'h14

// control register fields
`define STFS_CTRL_START   0
`define STFS_CTRL_WRITE   1
`define STFS_CTRL_FLD_LO  2
`define STFS_CTRL_FLD_HI  4
`define STFS_CTRL_LOCBUF  5

// status register fields
`define STFS_STAT_BUSY    0
`define STFS_STAT_LOC_LO  4
`define STFS_STAT_LOC_HI  15

// field designator codes
`define STFS_FLD_WHOLE    3'h0
`define STFS_FLD_LOW15    3'h4

// reset values
`define STFS_RST_WORD     24'h000000
`define STFS_RST_LOC      12'h000
`define STFS_RST_FLD      3'h0
`define STFS_RST_BUS      32'h00000000

`endif

/* File: pkg/stfs_pkg.sv */
// stfs_pkg - types shared by the storage transfer block.
// assumes stfs_map.svh is on the include path.
package stfs_pkg;
    // reference sequencer states
    typedef enum logic [2:0] {
        STFS_IDLE,
        STFS_CLEAR,
        STFS_SENSE,
        STFS_LOAD,
        STFS_XFER,
        STFS_RESTORE
    } stfs_state_t;
endpackage

/* File: verification/stfs_storage_transfer_monitor.sv */
// stfs_storage_transfer_monitor - port-level checks of the block.
// assumes stfs_map.svh on the include path; bound to the block below.
`include "stfs_map.svh"
module stfs_storage_transfer_monitor
    import stfs_pkg::*;
(
    input  wire logic                     core_clk,
    input  wire logic                     rstn,
    input  wire logic [`STFS_BUS_AW-1:0]  avs_address,
    input  wire logic                     avs_read,
    input  wire logic                     avs_write,
    input  wire logic [31:0]              avs_readdata,
    input  wire logic                     avs_waitrequest,
    input  wire logic [`STFS_WORD_W-1:0]  panel_lamp,
    input  wire logic [`STFS_ADDR_W-1:0]  line_select,
    input  wire logic                     busy
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // --------------------------------
    // reference sequencing
    // --------------------------------
    property p_busy_len; $rose(busy) |-> busy [*5] ##1 !busy; endproperty
    a_busy_len: assert property (p_busy_len) else $error("reference length wrong");
    property p_loc_load; $changed(line_select) |-> $rose(busy); endproperty
    a_loc_load: assert property (p_loc_load) else $error("locator moved off start");
    property p_loc_hold; busy && $past(busy) |-> $stable(line_select); endproperty
    a_loc_hold: assert property (p_loc_hold) else $error("locator moved in reference");
    // buffer must be empty before the sensed word lands
    property p_clear; $rose(busy) |=> panel_lamp == 24'h000000; endproperty
    a_clear: assert property (p_clear) else $error("buffer not cleared");
    // --------------------------------
    // bus handshake
    // --------------------------------
    // stalling the bus keeps field and operand fixed through a reference
    property p_stall; busy |-> avs_waitrequest; endproperty
    a_stall: assert property (p_stall) else $error("bus not stalled");
    property p_wr_fast; avs_write && !busy |-> !avs_waitrequest; endproperty
    a_wr_fast: assert property (p_wr_fast) else $error("write not answered");
    property p_rd_wait;
        $rose(avs_read) && !busy |-> avs_waitrequest ##1 !avs_waitrequest;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
    property p_status;
        avs_read && !avs_waitrequest && avs_address == `STFS_OFS_STATUS
            |-> avs_readdata[15:4] == line_select;
    endproperty
    a_status: assert property (p_status) else $error("status locator wrong");
    property p_lamp;
        avs_read && !avs_waitrequest && avs_address == `STFS_OFS_BUFFER
            |-> avs_readdata[23:0] == panel_lamp;
    endproperty
    a_lamp: assert property (p_lamp) else $error("lamp differs from buffer");
endmodule
bind stfs_storage_transfer stfs_storage_transfer_monitor u_stfs_storage_transfer_monitor (
    .core_clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_readdata,
    .avs_waitrequest, .panel_lamp, .line_select, .busy
);

/* File: verification/stfs_store_shadow.sv */
// stfs_store_shadow - reference copy of the core store for the bench.
// assumes the bench pulses upd for one edge after each write reference.
`include "stfs_map.svh"
module stfs_store_shadow
    import stfs_pkg::*;
(
    input  wire logic                     core_clk,
    input  wire logic                     upd,
    input  wire logic [`STFS_ADDR_W-1:0]  addr,
    input  wire logic [`STFS_WORD_W-1:0]  wdata,
    output logic      [`STFS_WORD_W-1:0]  rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // one word per twelve-bit address; unwritten words read unknown
    logic [`STFS_WORD_W-1:0] mem_ff [`STFS_DEPTH];
    always_ff @(posedge core_clk) if (upd) mem_ff[addr] <= wdata;
    assign rdata = mem_ff[addr];
endmodule

/* File: verification/testbench.sv */
// testbench - random and corner references through the register bus.
// assumes the block, its package, the shadow store and the monitor.
`include "stfs_map.svh"
module testbench
    import stfs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [23:0] panel_set_bit = 24'h000000;
    logic [23:0] panel_lamp;
    logic [11:0] line_select;
    logic        busy;
    logic        sh_upd = 1'b0;
    logic [11:0] sh_addr = 12'h000;
    logic [23:0] sh_wdata = 24'h000000;
    logic [23:0] sh_rdata;
    logic [23:0] cur_op;
    logic [31:0] rs = 32'h00000035;
    logic [31:0] q;
    int          n_fail = 0;
    int          comparisons = 0;
    stfs_storage_transfer u_stfs_storage_transfer (
        .core_clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .panel_set_bit,
        .panel_lamp, .line_select, .busy
    );
    stfs_store_shadow u_stfs_store_shadow (
        .core_clk, .upd(sh_upd), .addr(sh_addr), .wdata(sh_wdata), .rdata(sh_rdata)
    );
    // --------------------------------
    // helpers
    // --------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [23:0] f_extract(input logic [23:0] w, input logic [2:0] m);
        logic [7:0] b;
        if (m == 3'h0) return w;
        if (m == 3'h4) return {9'h000, w[14:0]};
        b = 8'(w >> (8 * (m[1:0] - 2'h1)));
        if (m[2]) return {16'h0000, b};
        return {{16{b[7]}}, b};
    endfunction
    function automatic logic [23:0] f_merge(input logic [23:0] o, input logic [23:0] x,
                                            input logic [2:0] m);
        logic [23:0] k;
        if (m == 3'h0) return x;
        if (m == 3'h4) return {o[23:15], x[14:0]};
        k = 24'h0000FF << (8 * (m[1:0] - 2'h1));
        return (o & ~k) | ((24'(x[7:0]) << (8 * (m[1:0] - 2'h1))) & k);
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one bus transfer; the request stands until waitrequest is seen low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0 && n < 200) begin
            @(posedge core_clk);
            n++;
        end
        if (n == 200) n_fail++;
        r = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge core_clk);
    endtask
    // start a reference, wait it out, then mirror a write in the shadow
    task automatic do_ref(input logic w, input logic [2:0] m);
        int n;
        logic [31:0] r;
        n = 0;
        bus(1'b1, `STFS_OFS_CTRL, {27'h0, m, w, 1'b1}, r);
        while (busy !== 1'b0 && n < 50) begin
            @(posedge core_clk);
            n++;
        end
        if (n == 50) n_fail++;
        if (w) begin
            sh_wdata <= f_merge(sh_rdata, cur_op, m);
            sh_upd <= 1'b1;
            @(posedge core_clk);
            sh_upd <= 1'b0;
        end
    endtask
    task automatic results();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // --------------------------------
    // clock, watchdog, main sequence
    // --------------------------------
    initial begin
        forever #12.5 core_clk = ~core_clk;
    end
    initial begin
        repeat (40000) @(posedge core_clk);
        n_fail++;
        results();
    end
    initial begin
        repeat (10) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        check({19'h0, busy, line_select}, 32'h0);
        check({8'h0, panel_lamp}, 32'h0);
        bus(1'b1, 5'h1C, 32'hFFFFFFFF, q);
        bus(1'b0, 5'h1C, 32'h0, q);
        check(q, 32'h0);
        for (int i = 0; i < 24; i++) begin
            rs = lfsr(rs);
            sh_addr <= (i < 2) ? {12{i[0]}} : rs[11:0];
            bus(1'b1, `STFS_OFS_NEXTLOC, {20'h0, (i < 2) ? {12{i[0]}} : rs[11:0]}, q);
            rs = lfsr(rs);
            cur_op = (i < 2) ? (i[0] ? 24'h807F80 : 24'h7F807F) : rs[23:0];
            bus(1'b1, `STFS_OFS_OPERAND, {8'h0, cur_op}, q);
            do_ref(1'b1, 3'h0);
            rs = lfsr(rs);
            cur_op = rs[23:0];
            bus(1'b1, `STFS_OFS_OPERAND, {8'h0, cur_op}, q);
            do_ref(1'b1, i[2:0]);
            for (int k = 0; k < 8; k++) begin
                do_ref(1'b0, k[2:0]);
                bus(1'b0, `STFS_OFS_OPERAND, 32'h0, q);
                check(q, {8'h0, f_extract(sh_rdata, k[2:0])});
            end
            bus(1'b0, `STFS_OFS_BUFFER, 32'h0, q);
            check(q, {8'h0, sh_rdata});
            bus(1'b0, `STFS_OFS_ORDER, 32'h0, q);
            check(q, {8'h0, sh_rdata});
            bus(1'b0, `STFS_OFS_STATUS, 32'h0, q);
            check({16'h0, q[15:4], 4'h0}, {16'h0, sh_addr, 4'h0});
        end
        // locator copy into buffer, read-only write ignored, then a button press
        bus(1'b1, `STFS_OFS_NEXTLOC, 32'h00000A5C, q);
        bus(1'b1, `STFS_OFS_CTRL, 32'h00000020, q);
        bus(1'b1, `STFS_OFS_BUFFER, 32'h00FFFFFF, q);
        bus(1'b0, `STFS_OFS_BUFFER, 32'h0, q);
        check(q, 32'h00000A5C);
        panel_set_bit <= 24'h800001;
        for (int n = 0; n < 20 && panel_lamp !== 24'h800A5D; n++) @(posedge core_clk);
        check({8'h0, panel_lamp}, 32'h00800A5D);
        panel_set_bit <= 24'h000000;
        @(posedge core_clk);
        results();
    end
endmodule

/* File: verilog/stfs_core_store.sv */
// stfs_core_store - the core store array, one 24-bit word per address.
// assumes one clock; read data come out of a register one edge later.
`include "stfs_map.svh"
module stfs_core_store
    import stfs_pkg::*;
(
    input  wire logic                     core_clk,
    input  wire logic [`STFS_ADDR_W-1:0]  addr,
    input  wire logic                     we,
    input  wire logic [`STFS_WORD_W-1:0]  wdata,
    output logic      [`STFS_WORD_W-1:0]  rdata_ff
);
    // --------------------------------------------------------------
    // array
    // --------------------------------------------------------------
    logic [`STFS_WORD_W-1:0] mem [0:`STFS_DEPTH-1];

    // no reset: the array keeps its contents like the planes it models
    always_ff @(posedge core_clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata_ff <= mem[addr];
    end
endmodule

/* File: verilog/stfs_field_path.sv */
// stfs_field_path - field-select paths between buffer and operand.
// assumes the field designator is held steady by the caller.
`include "stfs_map.svh"
module stfs_field_path
    import stfs_pkg::*;
(
    input  wire logic [`STFS_FIELD_W-1:0] field,
    input  wire logic [`STFS_WORD_W-1:0]  buffer,
    input  wire logic [`STFS_WORD_W-1:0]  operand,
    output logic      [`STFS_WORD_W-1:0]  extract,
    output logic      [`STFS_WORD_W-1:0]  insert,
    output logic      [`STFS_WORD_W-1:0]  keep_mask
);
    // --------------------------------------------------------------
    // steering stages
    // --------------------------------------------------------------
    wire logic       partial = (field != `STFS_FLD_WHOLE) && (field != `STFS_FLD_LOW15);
    wire logic [1:0] third   = field[1:0];        // 1 right, 2 centre, 3 left
    wire logic       signed_x = ~field[2];
    wire logic [`STFS_BYTE_W-1:0] steer =
        (third == 2'h1) ? buffer[7:0]  :
        (third == 2'h2) ? buffer[15:8] :
        (third == 2'h3) ? buffer[23:16] : 8'h00;
    wire logic       ext_bit = signed_x & steer[`STFS_BYTE_W-1];

    // read extraction into the operand register
    assign extract = (field == `STFS_FLD_WHOLE) ? buffer :
                     (field == `STFS_FLD_LOW15) ? {9'h000, buffer[14:0]} :
                     partial ? {{16{ext_bit}}, steer} : `STFS_RST_WORD;

    // --------------------------------------------------------------
    // write merge: operand bits placed in the chosen field
    // --------------------------------------------------------------
    genvar b;
    generate
        for (b = 0; b < `STFS_WORD_W; b = b + 1) begin : g_bit
            wire logic sel = (field == `STFS_FLD_WHOLE) ? 1'b1 :
                             (field == `STFS_FLD_LOW15) ? (b < `STFS_LOW15_W) :
                             ((b / `STFS_BYTE_W) == (third - 2'h1));
            wire logic src = (field == `STFS_FLD_WHOLE || field == `STFS_FLD_LOW15) ?
                             operand[b] : operand[b % `STFS_BYTE_W];
            assign insert[b]    = sel & src;
            assign keep_mask[b] = ~sel;
        end
    endgenerate
endmodule

/* File: verilog/stfs_storage_transfer.sv */
// stfs_storage_transfer - memory buffer, field select and locator logic
// between the core store and the operand register, reached over
// Avalon-MM with waitrequest.
// assumes a single 40 MHz core_clk, rstn asynchronous active low, and
// panel pushbuttons arriving asynchronously from the display panel.
// one reference at a time; the bus stalls while it runs.
// the array sits inside and keeps its words through reset.
//
// Notes on behaviour
// - memory locator holds the reference address, loaded only from next order locator
// - all reference data passes through the memory buffer, never straight to operand
// - memory buffer is cleared to zero before anything is transmitted into it
// - field zero read: whole buffer word copied into operand
// - field one read: right byte, upper bits copy bit eight
// - field two read: centre byte, upper bits copy bit sixteen
// - field three read: left byte, upper bits copy word's top bit
// - field four read: low fifteen bits, upper nine bits zero
// - fields five to seven read: right, centre, left byte zero extended
// - byte steering used only when field is neither zero nor four
// - steering picks right, middle or left third by field
// - fields one to three: steered top bit fills the sixteen upper bits
// - buffer input stage takes operand data and feeds operand for whole/low15
// - buffer middle stage loads from next locator or pushbutton, drives lamp
// - buffer output stage captures sensed bit, drives order word and steering
// - write offers five operand-to-buffer paths chosen by field
// - write replaces only the selected field, other bits keep old values
// - write sense keeps only preserved bits: none, all but byte, left nine
// - read loads the whole stored word regardless of field
// - array address is twelve bits, one word per reference
//
// The Avalon-MM slave port and the placing of the registers were decided locally.
`include "stfs_map.svh"
module stfs_storage_transfer
    import stfs_pkg::*;
(
    input  wire logic                      core_clk,
    input  wire logic                      rstn,
    input  wire logic [`STFS_BUS_AW-1:0]   avs_address,
    input  wire logic                      avs_read,
    input  wire logic                      avs_write,
    input  wire logic [31:0]               avs_writedata,
    input  wire logic [3:0]                avs_byteenable,
    output logic      [31:0]               avs_readdata,
    output logic                           avs_waitrequest,
    input  wire logic [`STFS_WORD_W-1:0]   panel_set_bit,
    output logic      [`STFS_WORD_W-1:0]   panel_lamp,
    output logic      [`STFS_ADDR_W-1:0]   line_select,
    output logic                           busy
);
    // --------------------------------------------------------------
    // state and registers
    // --------------------------------------------------------------
    stfs_state_t                state_ff;
    stfs_state_t                nxt_state;

    logic [`STFS_WORD_W-1:0]    buffer_ff;        // memory buffer
    logic [`STFS_WORD_W-1:0]    nxt_buffer;

    logic [`STFS_WORD_W-1:0]    operand_ff;       // operand register
    logic [`STFS_WORD_W-1:0]    order_word_ff;    // order word register

    logic [`STFS_ADDR_W-1:0]    next_loc_ff;      // next order locator
    logic [`STFS_ADDR_W-1:0]    locator_ff;       // memory locator
    logic [`STFS_FIELD_W-1:0]   field_ff;         // field designator
    logic                       dir_write_ff;

    logic                       rd_ack_ff;
    logic [31:0]                readdata_ff;

    logic [`STFS_WORD_W-1:0]    pb_s1_ff;
    logic [`STFS_WORD_W-1:0]    pb_s2_ff;
    logic [`STFS_WORD_W-1:0]    pb_s3_ff;

    logic [`STFS_WORD_W-1:0]    pb_prev_ff;

    // field path and array results
    wire logic [`STFS_WORD_W-1:0] sensed;

    wire logic [`STFS_WORD_W-1:0] extract;
    wire logic [`STFS_WORD_W-1:0] insert;
    wire logic [`STFS_WORD_W-1:0] keep_mask;

    // --------------------------------------------------------------
    // bus decode
    // --------------------------------------------------------------
    // every access waits while a reference runs, so nothing a reference
    // depends on can move under it
    wire logic idle       = (state_ff == STFS_IDLE);

    wire logic hit_ctrl   = (avs_address == `STFS_OFS_CTRL);
    wire logic hit_next   = (avs_address == `STFS_OFS_NEXTLOC);
    wire logic hit_oper   = (avs_address == `STFS_OFS_OPERAND);
    wire logic hit_buffer = (avs_address == `STFS_OFS_BUFFER);
    wire logic hit_order  = (avs_address == `STFS_OFS_ORDER);
    wire logic hit_status = (avs_address == `STFS_OFS_STATUS);

    // strobes qualified by idle
    wire logic wr_ok      = avs_write & idle;

    wire logic rd_take    = avs_read & idle & ~rd_ack_ff;

    wire logic wr_ctrl    = wr_ok & hit_ctrl & avs_byteenable[0];
    wire logic start_ref  = wr_ctrl & avs_writedata[`STFS_CTRL_START];
    wire logic loc_to_buf = wr_ctrl & avs_writedata[`STFS_CTRL_LOCBUF];

    wire logic [`STFS_FIELD_W-1:0] wr_field =
        avs_writedata[`STFS_CTRL_FLD_HI:`STFS_CTRL_FLD_LO];

    // waitrequest: busy stalls all, a read takes one extra edge
    // writes never wait while idle
    assign avs_waitrequest = ~idle | (avs_read & ~rd_ack_ff);

    assign avs_readdata    = readdata_ff;
    assign busy            = ~idle;

    // read data selection, unmapped addresses read as zero
    wire logic [31:0] status_word =
        {16'h0000, locator_ff, 3'h0, ~idle};

    // one decoded register per address
    wire logic [31:0] rd_mux =
        hit_ctrl   ? {26'h0000000, 1'b0, field_ff, dir_write_ff, 1'b0} :
        hit_next   ? {20'h00000, next_loc_ff} :
        hit_oper   ? {8'h00, operand_ff} :
        hit_buffer ? {8'h00, buffer_ff} :
        hit_order  ? {8'h00, order_word_ff} :
        hit_status ? status_word : `STFS_RST_BUS;

    // operand byte-lane write of the operand register
    wire logic [`STFS_WORD_W-1:0] oper_lane;
    // lane three is ignored
    genvar l;
    generate
        for (l = 0; l < 3; l = l + 1) begin : g_lane
            assign oper_lane[l*8 +: 8] = avs_byteenable[l] ?
                avs_writedata[l*8 +: 8] : operand_ff[l*8 +: 8];
        end
    endgenerate

    // --------------------------------------------------------------
    // field select and core store
    // --------------------------------------------------------------
    // pure decode of held registers
    stfs_field_path u_path (
        .field     (field_ff),
        .buffer    (buffer_ff),
        .operand   (operand_ff),
        .extract   (extract),
        .insert    (insert),
        .keep_mask (keep_mask)
    );

    // array is addressed only by the memory locator
    // written back in the restore step only
    wire logic store_we = (state_ff == STFS_RESTORE);

    stfs_core_store u_store (
        .core_clk (core_clk),
        .addr     (locator_ff),
        .we       (store_we),
        .wdata    (buffer_ff),
        .rdata_ff (sensed)
    );

    // pins straight from registers
    assign line_select = locator_ff;
    assign panel_lamp  = buffer_ff;

    // --------------------------------------------------------------
    // panel pushbutton synchroniser
    // --------------------------------------------------------------
    // three stages; a press counts when the second and third are both set
    wire logic [`STFS_WORD_W-1:0] pb_stable = pb_s2_ff & pb_s3_ff;

    wire logic [`STFS_WORD_W-1:0] pb_press  = pb_stable & ~pb_prev_ff;

    // only stage two reads stage one
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pb_s1_ff   <= `STFS_RST_WORD;
            pb_s2_ff   <= `STFS_RST_WORD;
            pb_s3_ff   <= `STFS_RST_WORD;
            pb_prev_ff <= `STFS_RST_WORD;
        end else begin
            pb_s1_ff   <= panel_set_bit;
            pb_s2_ff   <= pb_s1_ff;
            pb_s3_ff   <= pb_s2_ff;
            pb_prev_ff <= pb_stable;
        end
    end

    // --------------------------------------------------------------
    // reference sequencer
    // --------------------------------------------------------------
    // clear, sense, load, transfer, restore: one pass per reference
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            STFS_IDLE: begin
                if (start_ref) begin
                    nxt_state = STFS_CLEAR;
                end
            end

            // fixed walk, no stall
            STFS_CLEAR:   nxt_state = STFS_SENSE;
            STFS_SENSE:   nxt_state = STFS_LOAD;
            STFS_LOAD:    nxt_state = STFS_XFER;
            STFS_XFER:    nxt_state = STFS_RESTORE;
            STFS_RESTORE: nxt_state = STFS_IDLE;

            default:      nxt_state = STFS_IDLE;
        endcase
    end

    // --------------------------------------------------------------
    // memory buffer next value
    // --------------------------------------------------------------
    // a buffer with its selected field cleared is the only thing a transfer ever ORs into,
    // so stale bits from the last reference can never leak through
    always_comb begin
        nxt_buffer = buffer_ff;
        case (state_ff)
            STFS_IDLE: begin
                // copy beats a press
                if (loc_to_buf) begin
                    nxt_buffer = {12'h000, next_loc_ff};
                end else begin
                    nxt_buffer = buffer_ff | pb_press;
                end
            end

            STFS_CLEAR: nxt_buffer = `STFS_RST_WORD;
            STFS_SENSE: nxt_buffer = buffer_ff;

            STFS_LOAD: begin
                if (dir_write_ff) begin
                    nxt_buffer = sensed & keep_mask;
                end else begin
                    nxt_buffer = sensed;
                end
            end

            STFS_XFER: begin
                if (dir_write_ff) begin
                    nxt_buffer = buffer_ff | insert;
                end
            end

            STFS_RESTORE: nxt_buffer = buffer_ff;

            default:      nxt_buffer = buffer_ff;
        endcase
    end

    // read hands its field over here
    wire logic read_xfer = (state_ff == STFS_XFER) & ~dir_write_ff;

    // --------------------------------------------------------------
    // sequencer and buffer registers
    // --------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_ff  <= STFS_IDLE;
            buffer_ff <= `STFS_RST_WORD;
        end else begin
            // state and buffer move together
            state_ff  <= nxt_state;
            buffer_ff <= nxt_buffer;
        end
    end

    // --------------------------------------------------------------
    // operand and order word registers
    // --------------------------------------------------------------
    // operand takes bus writes only while idle, reads only via buffer
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            operand_ff    <= `STFS_RST_WORD;
            order_word_ff <= `STFS_RST_WORD;
        end else if (read_xfer) begin
            // result and raw word on one edge
            operand_ff    <= extract;
            order_word_ff <= buffer_ff;
        end else if (wr_ok & hit_oper) begin
            // lanes merge over held bits
            operand_ff    <= oper_lane;
        end
    end

    // --------------------------------------------------------------
    // locators and control fields
    // --------------------------------------------------------------
    // field and direction latch at start and hold for the reference
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            next_loc_ff  <= `STFS_RST_LOC;
            locator_ff   <= `STFS_RST_LOC;
            field_ff     <= `STFS_RST_FLD;
            dir_write_ff <= 1'b0;
        end else begin
            // next locator, two lanes
            if (wr_ok & hit_next & avs_byteenable[0]) begin
                next_loc_ff[7:0] <= avs_writedata[7:0];
            end

            if (wr_ok & hit_next & avs_byteenable[1]) begin
                next_loc_ff[11:8] <= avs_writedata[11:8];
            end

            // start also loads the locator
            if (start_ref) begin
                locator_ff   <= next_loc_ff;
                field_ff     <= wr_field;
                dir_write_ff <= avs_writedata[`STFS_CTRL_WRITE];
            end else if (wr_ctrl) begin
                // plain control write, locator kept
                field_ff     <= wr_field;
                dir_write_ff <= avs_writedata[`STFS_CTRL_WRITE];
            end
        end
    end

    // --------------------------------------------------------------
    // bus read data
    // --------------------------------------------------------------
    // registered read data cost one wait cycle but keep the output
    // free of the decode mux
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rd_ack_ff   <= 1'b0;
            readdata_ff <= `STFS_RST_BUS;
        end else begin
            // ack lasts one edge
            rd_ack_ff <= rd_take;

            if (rd_take) begin
                readdata_ff <= rd_mux;
            end
        end
    end
endmodule
